// file: design/link_core_crypto_test_timer_regs.sv
// Register slice: cipher key and pointer, integrity results, radio test
// controls with pseudo-random payload generator, timer targets, capture.
// Assumes a classic Wishbone master and a free-running base time counter
// synchronous to REF_CLK.
//
// Decided for this implementation: register access over Wishbone.

`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Key bits 63..32, 95..64, 127..96 in three consecutive RW words, reset zero.
// - Key bits 31..0 in an RW word just below the upper key words.
// - Writing start launches ciphering; bit clears when the cipher completes, masked or not.
// - Sixteen-bit RW block pointer sits in the low half of its word.
// - Read-only TX and RX integrity words, valid at cipher completion, masked or not.
// - Bit 31 set keeps the receive window open for every frame format.
// - Bit 15 set starts a packet normally then sends payload endlessly.
// - Endless payload without pseudo-random source repeats a pattern of test length.
// - Bit 14 picks payload size: descriptor length, or test length up to 511.
// - Bit 13 picks the pseudo-random kind: 9-stage or 15-stage sequence.
// - Nine-stage generator uses 1+x^5+x^9, seeded all ones.
// - Fifteen-stage generator uses 1+x+x^2+x^12+x^13+x^14, seeded all ones.
// - Bit 12 picks payload origin: memory control structure or pseudo-random generator.
// - Test length is nine bits at 8..0, in bytes.
// - Eight-bit RW exchange-table prefetch time in microseconds.
// - Coarse match when target equals counter 19..4 and counter 3..0 is zero.
// - Fine match when 27-bit target equals the whole base time counter.
// - Writing capture bit samples the counter; bit self-clears after capture.
module link_core_crypto_test_timer_regs (
   input  wire  logic         REF_CLK,
   input  wire  logic         RESETN,
   // Wishbone slave
   input  wire  logic [31:0]  ADR_I,
   input  wire  logic [31:0]  DAT_I,
   output logic       [31:0]  DAT_O,
   input  wire  logic         WE_I,
   input  wire  logic [3:0]   SEL_I,
   input  wire  logic         CYC_I,
   input  wire  logic         STB_I,
   output logic               ACK_O,
   output logic               IRQ,
   // Cipher engine
   output logic       [127:0] CIPHER_KEY,
   output logic       [15:0]  CIPHER_BLOCK_PTR,
   output logic               CIPHER_START,
   input  wire  logic         CIPHER_DONE,
   input  wire  logic [31:0]  TX_INTEGRITY_IN,
   input  wire  logic [31:0]  RX_INTEGRITY_IN,
   // Radio datapath
   output logic               ENDLESS_RECEIVE,
   output logic               ENDLESS_TRANSMIT,
   output logic               PAYLOAD_SIZE_SELECT,
   output logic               PSEUDO_RANDOM_KIND,
   output logic               PAYLOAD_ORIGIN_SELECT,
   output logic       [8:0]   TEST_PAYLOAD_BYTES,
   input  wire  logic [7:0]   DESCRIPTOR_ADV_LENGTH,
   output logic       [9:0]   PAYLOAD_LENGTH,
   output logic               REPEAT_PATTERN,
   input  wire  logic         PRBS_LOAD,
   input  wire  logic         PRBS_ADVANCE,
   output logic               PRBS_BIT,
   output logic       [7:0]   EXCHANGE_PREFETCH_US,
   // Base time counter
   input  wire  logic [26:0]  BASE_TIME_COUNT
);

   // ------------------------
   // Storage
   // ------------------------
   logic [31:0] key_word [0:3];
   logic        cipher_start;
   logic [15:0] cipher_block_ptr;
   logic [31:0] tx_integrity_word;
   logic [31:0] rx_integrity_word;
   logic [31:0] radio_test_ctl;
   logic [7:0]  exchange_prefetch_us;
   logic [15:0] coarse_match_value;
   logic [26:0] fine_match_value;
   logic        capture_now;
   logic [26:0] base_time_sample;
   logic [2:0]  event_status;
   logic [2:0]  event_enable;
   logic        coarse_hit_d;
   logic        fine_hit_d;
   logic [8:0]  prbs9;
   logic [14:0] prbs15;
   logic        ack;
   logic [31:0] read_data;

   // ------------------------
   // Bus decode
   // ------------------------
   wire         access      = CYC_I & STB_I & ~ack;
   wire         wr          = access & WE_I;
   wire [31:0]  byte_mask   = {{8{SEL_I[3]}}, {8{SEL_I[2]}}, {8{SEL_I[1]}}, {8{SEL_I[0]}}};
   wire         sel_ctl     = ADR_I == link_regs_pkg::ADDR_CIPHER_CONTROL;
   wire         sel_key0    = ADR_I == link_regs_pkg::ADDR_CIPHER_KEY_WORD0;
   wire         sel_key1    = ADR_I == link_regs_pkg::ADDR_CIPHER_KEY_WORD1;
   wire         sel_key2    = ADR_I == link_regs_pkg::ADDR_CIPHER_KEY_WORD2;
   wire         sel_key3    = ADR_I == link_regs_pkg::ADDR_CIPHER_KEY_WORD3;
   wire         sel_ptr     = ADR_I == link_regs_pkg::ADDR_CIPHER_BLOCK_POINTER;
   wire         sel_txmic   = ADR_I == link_regs_pkg::ADDR_TX_INTEGRITY_VALUE;
   wire         sel_rxmic   = ADR_I == link_regs_pkg::ADDR_RX_INTEGRITY_VALUE;
   wire         sel_test    = ADR_I == link_regs_pkg::ADDR_RADIO_TEST_CONTROL;
   wire         sel_tgen    = ADR_I == link_regs_pkg::ADDR_TIMING_GEN_CONTROL;
   wire         sel_coarse  = ADR_I == link_regs_pkg::ADDR_COARSE_TIMER_TARGET;
   wire         sel_fine    = ADR_I == link_regs_pkg::ADDR_FINE_TIMER_TARGET;
   wire         sel_capt    = ADR_I == link_regs_pkg::ADDR_CAPTURE_TRIGGER;
   wire         sel_sample  = ADR_I == link_regs_pkg::ADDR_BASE_TIME_SAMPLE;
   wire         sel_status  = ADR_I == link_regs_pkg::ADDR_EVENT_STATUS;
   wire         sel_clear   = ADR_I == link_regs_pkg::ADDR_EVENT_CLEAR;
   wire         sel_enable  = ADR_I == link_regs_pkg::ADDR_EVENT_ENABLE;

   // Only the written lanes change; unmapped addresses ack and read zero.
   wire [31:0]  wdata       = DAT_I & byte_mask;
   wire [31:0]  merged      = (read_data & ~byte_mask) | wdata;
   wire         wr_start    = wr & sel_ctl & SEL_I[0] & DAT_I[link_regs_pkg::BIT_CIPHER_START];
   wire         wr_capture  = wr & sel_capt & SEL_I[0] & DAT_I[link_regs_pkg::BIT_CAPTURE_NOW];
   wire [2:0]   clear_bits  = (wr & sel_clear) ? wdata[2:0] : 3'h0;

   // ------------------------
   // Read mux
   // ------------------------
   wire [31:0]  rd_ctl      = {31'h0, cipher_start};
   wire [31:0]  rd_ptr      = {16'h0, cipher_block_ptr};
   wire [31:0]  rd_tgen     = {24'h0, exchange_prefetch_us};
   wire [31:0]  rd_coarse   = {16'h0, coarse_match_value};
   wire [31:0]  rd_fine     = {5'h0, fine_match_value};
   wire [31:0]  rd_capt     = {31'h0, capture_now};
   wire [31:0]  rd_sample   = {5'h0, base_time_sample};
   wire [31:0]  rd_status   = {29'h0, event_status};
   wire [31:0]  rd_enable   = {29'h0, event_enable};

   always_comb begin
      read_data = link_regs_pkg::RESET_WORD;
      if (sel_ctl)    read_data = rd_ctl;
      if (sel_key0)   read_data = key_word[0];
      if (sel_key1)   read_data = key_word[1];
      if (sel_key2)   read_data = key_word[2];
      if (sel_key3)   read_data = key_word[3];
      if (sel_ptr)    read_data = rd_ptr;
      if (sel_txmic)  read_data = tx_integrity_word;
      if (sel_rxmic)  read_data = rx_integrity_word;
      if (sel_test)   read_data = radio_test_ctl;
      if (sel_tgen)   read_data = rd_tgen;
      if (sel_coarse) read_data = rd_coarse;
      if (sel_fine)   read_data = rd_fine;
      if (sel_capt)   read_data = rd_capt;
      if (sel_sample) read_data = rd_sample;
      if (sel_status) read_data = rd_status;
      if (sel_enable) read_data = rd_enable;
   end

   // ------------------------
   // Bus answer: one wait state, ack for exactly one cycle
   // ------------------------
   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         ack   <= 1'b0;
         DAT_O <= link_regs_pkg::RESET_WORD;
      end else begin
         ack   <= access;
         DAT_O <= (access & ~WE_I) ? read_data : link_regs_pkg::RESET_WORD;
      end
   end

   assign ACK_O = ack;

   // ------------------------
   // Key, pointer, test and timer configuration words
   // ------------------------
   wire [31:0] test_write_mask = 32'h8000_f1ff;

   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         for (int i = 0; i < 4; i++) begin
            key_word[i] <= link_regs_pkg::RESET_WORD;
         end
         cipher_block_ptr     <= 16'h0000;
         radio_test_ctl       <= link_regs_pkg::RESET_WORD;
         exchange_prefetch_us <= 8'h00;
         coarse_match_value   <= 16'h0000;
         fine_match_value     <= 27'h000_0000;
         event_enable         <= 3'h0;
      end else if (wr) begin
         if (sel_key0)   key_word[0]          <= merged;
         if (sel_key1)   key_word[1]          <= merged;
         if (sel_key2)   key_word[2]          <= merged;
         if (sel_key3)   key_word[3]          <= merged;
         if (sel_ptr)    cipher_block_ptr     <= merged[15:0];
         if (sel_test)   radio_test_ctl       <= merged & test_write_mask;
         if (sel_tgen)   exchange_prefetch_us <= merged[7:0];
         if (sel_coarse) coarse_match_value   <= merged[15:0];
         if (sel_fine)   fine_match_value     <= merged[26:0];
         if (sel_enable) event_enable         <= merged[2:0];
      end
   end

   assign CIPHER_KEY       = {key_word[3], key_word[2], key_word[1], key_word[0]};
   assign CIPHER_BLOCK_PTR = cipher_block_ptr;
   assign CIPHER_START     = cipher_start;

   // ------------------------
   // Cipher start and integrity results
   // ------------------------
   // A start written in the completion cycle wins, launching a new run.
   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         cipher_start <= 1'b0;
      end else if (wr_start) begin
         cipher_start <= 1'b1;
      end else if (CIPHER_DONE) begin
         cipher_start <= 1'b0;
      end
   end

   // Captured regardless of the enable mask
   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         tx_integrity_word <= link_regs_pkg::RESET_WORD;
         rx_integrity_word <= link_regs_pkg::RESET_WORD;
      end else if (CIPHER_DONE) begin
         tx_integrity_word <= TX_INTEGRITY_IN;
         rx_integrity_word <= RX_INTEGRITY_IN;
      end
   end

   // ------------------------
   // Radio test controls
   // ------------------------
   wire endless_rx   = radio_test_ctl[link_regs_pkg::BIT_ENDLESS_RECEIVE];
   wire endless_tx   = radio_test_ctl[link_regs_pkg::BIT_ENDLESS_TRANSMIT];
   wire size_select  = radio_test_ctl[link_regs_pkg::BIT_PAYLOAD_SIZE_SELECT];
   wire random_kind  = radio_test_ctl[link_regs_pkg::BIT_PSEUDO_RANDOM_KIND];
   wire origin_sel   = radio_test_ctl[link_regs_pkg::BIT_PAYLOAD_ORIGIN_SELECT];
   wire [8:0] bytes  = radio_test_ctl[link_regs_pkg::TEST_BYTES_MSB:0];

   assign ENDLESS_RECEIVE       = endless_rx;
   assign ENDLESS_TRANSMIT      = endless_tx;
   assign PAYLOAD_SIZE_SELECT   = size_select;
   assign PSEUDO_RANDOM_KIND    = random_kind;
   assign PAYLOAD_ORIGIN_SELECT = origin_sel;
   assign TEST_PAYLOAD_BYTES    = bytes;
   assign EXCHANGE_PREFETCH_US  = exchange_prefetch_us;

   // Nine-bit field caps the test length at 511; the datapath counts bytes.
   assign PAYLOAD_LENGTH = size_select ? {1'b0, bytes}
                                       : {2'b00, DESCRIPTOR_ADV_LENGTH};
   assign REPEAT_PATTERN = endless_tx & ~origin_sel;

   // ------------------------
   // Pseudo-random payload generators
   // ------------------------
   wire prbs9_fb  = prbs9[8] ^ prbs9[4];
   wire prbs15_fb = prbs15[13] ^ prbs15[12] ^ prbs15[11] ^ prbs15[1] ^ prbs15[0];

   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         prbs9  <= link_regs_pkg::PRBS9_SEED;
         prbs15 <= link_regs_pkg::PRBS15_SEED;
      end else if (PRBS_LOAD) begin
         prbs9  <= link_regs_pkg::PRBS9_SEED;
         prbs15 <= link_regs_pkg::PRBS15_SEED;
      end else if (PRBS_ADVANCE & origin_sel) begin
         prbs9  <= {prbs9[7:0], prbs9_fb};
         prbs15 <= {prbs15[13:0], prbs15_fb};
      end
   end

   // Zero while payload comes from memory, so the datapath may OR it in.
   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         PRBS_BIT <= 1'b0;
      end else begin
         PRBS_BIT <= origin_sel & (random_kind ? prbs15_fb : prbs9_fb);
      end
   end

   // ------------------------
   // Timer targets and counter capture
   // ------------------------
   wire coarse_hit = (coarse_match_value ==
                      BASE_TIME_COUNT[link_regs_pkg::COARSE_CNT_MSB:link_regs_pkg::COARSE_CNT_LSB])
                     && (BASE_TIME_COUNT[link_regs_pkg::COARSE_ZERO_MSB:0] == 4'h0);
   wire fine_hit   = fine_match_value == BASE_TIME_COUNT;

   // Edge of the match, so a stalled counter cannot retrigger
   wire coarse_event = coarse_hit & ~coarse_hit_d;
   wire fine_event   = fine_hit & ~fine_hit_d;

   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         coarse_hit_d <= 1'b0;
         fine_hit_d   <= 1'b0;
      end else begin
         coarse_hit_d <= coarse_hit;
         fine_hit_d   <= fine_hit;
      end
   end

   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         capture_now      <= 1'b0;
         base_time_sample <= 27'h000_0000;
      end else if (capture_now) begin
         base_time_sample <= BASE_TIME_COUNT;
         capture_now      <= 1'b0;
      end else if (wr_capture) begin
         capture_now <= 1'b1;
      end
   end

   // ------------------------
   // Interrupt status: set wins over a clear in the same cycle
   // ------------------------
   wire [2:0] event_set = {fine_event, coarse_event, CIPHER_DONE};

   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         event_status <= 3'h0;
      end else begin
         event_status <= (event_status & ~clear_bits) | event_set;
      end
   end

   assign IRQ = |(event_status & event_enable);

endmodule // link_core_crypto_test_timer_regs

`default_nettype wire

// file: design/link_regs_pkg.sv
// Package for the link-core cipher, radio-test and timer register slice.
// Assumes one clock domain and a classic Wishbone slave with 32-bit data.

package link_regs_pkg;

   // ------------------------
   // Register byte addresses
   // ------------------------
   localparam logic [31:0] ADDR_CIPHER_CONTROL       = 32'h4000_00c0;
   localparam logic [31:0] ADDR_CIPHER_KEY_WORD0     = 32'h4000_00c4;
   localparam logic [31:0] ADDR_CIPHER_KEY_WORD1     = 32'h4000_00c8;
   localparam logic [31:0] ADDR_CIPHER_KEY_WORD2     = 32'h4000_00cc;
   localparam logic [31:0] ADDR_CIPHER_KEY_WORD3     = 32'h4000_00d0;
   localparam logic [31:0] ADDR_CIPHER_BLOCK_POINTER = 32'h4000_00d4;
   localparam logic [31:0] ADDR_TX_INTEGRITY_VALUE   = 32'h4000_00d8;
   localparam logic [31:0] ADDR_RX_INTEGRITY_VALUE   = 32'h4000_00dc;
   localparam logic [31:0] ADDR_RADIO_TEST_CONTROL   = 32'h4000_00e0;
   localparam logic [31:0] ADDR_TIMING_GEN_CONTROL   = 32'h4000_00f0;
   localparam logic [31:0] ADDR_COARSE_TIMER_TARGET  = 32'h4000_00f4;
   localparam logic [31:0] ADDR_FINE_TIMER_TARGET    = 32'h4000_00f8;
   localparam logic [31:0] ADDR_CAPTURE_TRIGGER      = 32'h4000_00fc;
   localparam logic [31:0] ADDR_BASE_TIME_SAMPLE     = 32'h4000_0100;
   localparam logic [31:0] ADDR_EVENT_STATUS         = 32'h4000_0104;
   localparam logic [31:0] ADDR_EVENT_CLEAR          = 32'h4000_0108;
   localparam logic [31:0] ADDR_EVENT_ENABLE         = 32'h4000_010c;

   // ------------------------
   // Field positions
   // ------------------------
   localparam int BIT_CIPHER_START          = 0;
   localparam int BIT_CAPTURE_NOW           = 0;
   localparam int BIT_ENDLESS_RECEIVE       = 31;
   localparam int BIT_ENDLESS_TRANSMIT      = 15;
   localparam int BIT_PAYLOAD_SIZE_SELECT   = 14;
   localparam int BIT_PSEUDO_RANDOM_KIND    = 13;
   localparam int BIT_PAYLOAD_ORIGIN_SELECT = 12;
   localparam int TEST_BYTES_MSB            = 8;
   localparam int COARSE_CNT_LSB            = 4;
   localparam int COARSE_CNT_MSB            = 19;
   localparam int COARSE_ZERO_MSB           = 3;

   // ------------------------
   // Reset and seed values
   // ------------------------
   localparam logic [31:0] RESET_WORD  = 32'h0000_0000;
   localparam logic [8:0]  PRBS9_SEED  = 9'h1ff;
   localparam logic [14:0] PRBS15_SEED = 15'h7fff;

endpackage

// file: dv/link_regs_asserts.sv
// Checker for the link register slice: bus handshake, key and pointer
// writes, cipher start and payload controls. Bound onto the top ports.
`timescale 1ns/1ps
`default_nettype none
module link_regs_asserts (
   input wire logic         REF_CLK,
   input wire logic         RESETN,
   input wire logic [31:0]  ADR_I,
   input wire logic [31:0]  DAT_I,
   input wire logic [31:0]  DAT_O,
   input wire logic         WE_I,
   input wire logic [3:0]   SEL_I,
   input wire logic         CYC_I,
   input wire logic         STB_I,
   input wire logic         ACK_O,
   input wire logic [127:0] CIPHER_KEY,
   input wire logic [15:0]  CIPHER_BLOCK_PTR,
   input wire logic         CIPHER_START,
   input wire logic         CIPHER_DONE,
   input wire logic         ENDLESS_TRANSMIT,
   input wire logic         PAYLOAD_SIZE_SELECT,
   input wire logic         PAYLOAD_ORIGIN_SELECT,
   input wire logic [8:0]   TEST_PAYLOAD_BYTES,
   input wire logic [7:0]   DESCRIPTOR_ADV_LENGTH,
   input wire logic [9:0]   PAYLOAD_LENGTH,
   input wire logic         REPEAT_PATTERN
);
   // ------------------------
   // Request decode
   // ------------------------
   wire logic take     = CYC_I & STB_I & ~ACK_O;
   wire logic full_wr  = take & WE_I & (SEL_I == 4'hf);
   wire logic start_wr = take & WE_I & SEL_I[0] & DAT_I[0]
                         & (ADR_I == link_regs_pkg::ADDR_CIPHER_CONTROL);
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RESETN);
   // ------------------------
   // Properties
   // ------------------------
   a_ack_single: assert property (ACK_O |=> !ACK_O) else $error("ack longer than one cycle");
   a_ack_answer: assert property (take |=> ACK_O) else $error("request not answered");
   a_read_quiet: assert property (!ACK_O |-> DAT_O == 32'h0000_0000) else $error("data outside ack");
   a_key_upper: assert property (full_wr && ADR_I == link_regs_pkg::ADDR_CIPHER_KEY_WORD1
      |=> CIPHER_KEY[63:32] == $past(DAT_I)) else $error("key word one not stored");
   a_key_lower: assert property (full_wr && ADR_I == link_regs_pkg::ADDR_CIPHER_KEY_WORD0
      |=> CIPHER_KEY[31:0] == $past(DAT_I)) else $error("key word zero not stored");
   a_ptr_store: assert property (full_wr && ADR_I == link_regs_pkg::ADDR_CIPHER_BLOCK_POINTER
      |=> {16'h0000, CIPHER_BLOCK_PTR} == ($past(DAT_I) & 32'h0000_ffff)) else $error("pointer bad");
   a_start_set: assert property (start_wr |=> CIPHER_START) else $error("start not raised");
   a_start_clear: assert property (CIPHER_DONE && !start_wr |=> !CIPHER_START)
      else $error("start not cleared at completion");
   a_payload_len: assert property (PAYLOAD_LENGTH == (PAYLOAD_SIZE_SELECT ?
      {1'b0, TEST_PAYLOAD_BYTES} : {2'b00, DESCRIPTOR_ADV_LENGTH})) else $error("length bad");
   a_repeat_pat: assert property (REPEAT_PATTERN == (ENDLESS_TRANSMIT && !PAYLOAD_ORIGIN_SELECT))
      else $error("repeat pattern bad");
   c_cipher_done: cover property (CIPHER_DONE && CIPHER_START);
   c_radio_write: cover property (full_wr && ADR_I == link_regs_pkg::ADDR_RADIO_TEST_CONTROL);
   c_read_ack: cover property (ACK_O && !WE_I);
endmodule // link_regs_asserts
bind link_core_crypto_test_timer_regs link_regs_asserts u_asserts (.*);
`default_nettype wire

// file: dv/tb_link_core_crypto_test_timer_regs.sv
// Testbench for the link register slice: register access, cipher hand-off,
// radio test outputs, generator, timer events and capture.
// Assumes ACK_O answers one cycle after a request is taken.
`timescale 1ns/1ps
`default_nettype none
module tb_link_core_crypto_test_timer_regs;
   logic         REF_CLK               = 1'b0;
   logic         RESETN                = 1'b0;
   logic [31:0]  ADR_I                 = 32'h0000_0000;
   logic [31:0]  DAT_I                 = 32'h0000_0000;
   logic         WE_I                  = 1'b0;
   logic [3:0]   SEL_I                 = 4'h0;
   logic         CYC_I                 = 1'b0;
   logic         STB_I                 = 1'b0;
   logic         CIPHER_DONE           = 1'b0;
   logic [31:0]  TX_INTEGRITY_IN       = 32'h0000_0000;
   logic [31:0]  RX_INTEGRITY_IN       = 32'h0000_0000;
   logic [7:0]   DESCRIPTOR_ADV_LENGTH = 8'ha5;
   logic         PRBS_LOAD             = 1'b0;
   logic         PRBS_ADVANCE          = 1'b0;
   logic [26:0]  BASE_TIME_COUNT       = 27'h000_0001;
   logic [31:0]  DAT_O;
   logic         ACK_O, IRQ, CIPHER_START, ENDLESS_RECEIVE, ENDLESS_TRANSMIT, PRBS_BIT;
   logic         PAYLOAD_SIZE_SELECT, PSEUDO_RANDOM_KIND, PAYLOAD_ORIGIN_SELECT, REPEAT_PATTERN;
   logic [127:0] CIPHER_KEY;
   logic [15:0]  CIPHER_BLOCK_PTR;
   logic [8:0]   TEST_PAYLOAD_BYTES;
   logic [9:0]   PAYLOAD_LENGTH;
   logic [7:0]   EXCHANGE_PREFETCH_US;
   int           n_errors              = 0;
   int           n_compared            = 0;
   int           cycles                = 0;
   wire [5:0]    rt_bits = {ENDLESS_RECEIVE, ENDLESS_TRANSMIT, PAYLOAD_SIZE_SELECT,
                           PSEUDO_RANDOM_KIND, PAYLOAD_ORIGIN_SELECT, REPEAT_PATTERN};

   always #2.5 REF_CLK = ~REF_CLK;

   link_core_crypto_test_timer_regs u_dut (.*);

   // ------------------------
   // Bus and compare tasks
   // ------------------------
   task automatic complete_run();
      $display("Compared %0d, mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [127:0] exp, input logic [127:0] got);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Called just after a rising edge; holds everything until ack is sampled
   task automatic bus(input logic w, input logic [3:0] s, input logic [31:0] a, d,
                      output logic [31:0] q);
      ADR_I <= a;
      DAT_I <= d;
      WE_I  <= w;
      SEL_I <= s;
      CYC_I <= 1'b1;
      STB_I <= 1'b1;
      do @(posedge REF_CLK); while (ACK_O !== 1'b1);
      q = DAT_O;
      CYC_I <= 1'b0;
      STB_I <= 1'b0;
      WE_I  <= 1'b0;
      @(posedge REF_CLK);
   endtask

   task automatic wr(input logic [31:0] a, d);
      logic [31:0] q;
      bus(1'b1, 4'hf, a, d, q);
   endtask

   task automatic rd_chk(input string n, input logic [31:0] a, exp);
      logic [31:0] q;
      bus(1'b0, 4'h0, a, 32'h0000_0000, q);
      check(n, exp, q);
   endtask

   task automatic ones_chk(input string n, input logic [31:0] a, exp);
      wr(a, 32'hffff_ffff);
      rd_chk(n, a, exp);
   endtask

   task automatic cipher_run(input logic [31:0] v);
      TX_INTEGRITY_IN <= v;
      RX_INTEGRITY_IN <= ~v;
      wr(link_regs_pkg::ADDR_CIPHER_CONTROL, 32'h0000_0001);
      check("start_on", 1'b1, CIPHER_START);
      CIPHER_DONE <= 1'b1;
      @(posedge REF_CLK);
      CIPHER_DONE     <= 1'b0;
      TX_INTEGRITY_IN <= 32'h0000_0000;
      @(posedge REF_CLK);
      check("start_off", 1'b0, CIPHER_START);
      rd_chk("tx_mic", link_regs_pkg::ADDR_TX_INTEGRITY_VALUE, v);
      rd_chk("rx_mic", link_regs_pkg::ADDR_RX_INTEGRITY_VALUE, ~v);
   endtask

   // Cuts a hang short
   always @(posedge REF_CLK) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         complete_run();
      end
   end

   // ------------------------
   // Main sequence
   // ------------------------
   initial begin
      logic [31:0] q;
      logic [14:0] lfsr;
      logic        fb;
      repeat (20) @(posedge REF_CLK);
      RESETN <= 1'b1;
      @(posedge REF_CLK);
      for (int i = 0; i < 17; i++) begin
         rd_chk("reset", 32'h4000_00c0 + 32'(4 * i), 32'h0000_0000);
      end
      for (int i = 0; i < 4; i++) begin
         wr(link_regs_pkg::ADDR_CIPHER_KEY_WORD0 + 32'(4 * i), 32'(32'h1111_1111 * (i + 1)));
      end
      for (int i = 0; i < 4; i++) begin
         rd_chk("key", link_regs_pkg::ADDR_CIPHER_KEY_WORD0 + 32'(4 * i), 32'(32'h1111_1111 * (i + 1)));
      end
      check("key_out", 128'h4444_4444_3333_3333_2222_2222_1111_1111, CIPHER_KEY);
      bus(1'b1, 4'h1, link_regs_pkg::ADDR_CIPHER_KEY_WORD3, 32'h0000_00aa, q);
      rd_chk("lane", link_regs_pkg::ADDR_CIPHER_KEY_WORD3, 32'h4444_44aa);
      ones_chk("ptr", link_regs_pkg::ADDR_CIPHER_BLOCK_POINTER, 32'h0000_ffff);
      check("ptr_out", 16'hffff, CIPHER_BLOCK_PTR);
      ones_chk("prefetch", link_regs_pkg::ADDR_TIMING_GEN_CONTROL, 32'h0000_00ff);
      check("prefetch_out", 8'hff, EXCHANGE_PREFETCH_US);
      ones_chk("coarse_t", link_regs_pkg::ADDR_COARSE_TIMER_TARGET, 32'h0000_ffff);
      ones_chk("fine_t", link_regs_pkg::ADDR_FINE_TIMER_TARGET, 32'h07ff_ffff);
      ones_chk("mic_ro", link_regs_pkg::ADDR_TX_INTEGRITY_VALUE, 32'h0000_0000);
      ones_chk("unmapped", 32'h4000_00e4, 32'h0000_0000);
      // Cipher completion, enabled then masked
      wr(link_regs_pkg::ADDR_EVENT_ENABLE, 32'h0000_0001);
      cipher_run(32'hcafe_0001);
      check("irq_on", 1'b1, IRQ);
      wr(link_regs_pkg::ADDR_EVENT_CLEAR, 32'h0000_0001);
      check("irq_off", 1'b0, IRQ);
      wr(link_regs_pkg::ADDR_EVENT_ENABLE, 32'h0000_0006);
      cipher_run(32'h5a5a_1234);
      check("irq_mask", 1'b0, IRQ);
      rd_chk("status_m", link_regs_pkg::ADDR_EVENT_STATUS, 32'h0000_0001);
      wr(link_regs_pkg::ADDR_EVENT_CLEAR, 32'h0000_0001);
      rd_chk("clear_rd", link_regs_pkg::ADDR_EVENT_CLEAR, 32'h0000_0000);
      // Radio test controls and generator
      ones_chk("rtc", link_regs_pkg::ADDR_RADIO_TEST_CONTROL, 32'h8000_f1ff);
      check("rt_bits", 6'h3e, rt_bits);
      check("len_test", 10'h1ff, PAYLOAD_LENGTH);
      wr(link_regs_pkg::ADDR_RADIO_TEST_CONTROL, 32'h0000_8005);
      check("rt_rep", 6'h11, rt_bits);
      check("len_desc", 10'h0a5, PAYLOAD_LENGTH);
      check("bytes", 9'h005, TEST_PAYLOAD_BYTES);
      PRBS_ADVANCE <= 1'b1;
      repeat (3) @(posedge REF_CLK);
      check("prbs_off", 1'b0, PRBS_BIT);
      PRBS_ADVANCE <= 1'b0;
      // Nine-stage run, then fifteen-stage
      for (int k = 0; k < 2; k++) begin
         wr(link_regs_pkg::ADDR_RADIO_TEST_CONTROL, 32'h0000_1000 | 32'(k << 13));
         PRBS_LOAD <= 1'b1;
         @(posedge REF_CLK);
         PRBS_LOAD    <= 1'b0;
         PRBS_ADVANCE <= 1'b1;
         lfsr = 15'h7fff;
         // Each bit is seen one edge after the shift that made it
         for (int i = 0; i < 24; i++) begin
            @(posedge REF_CLK);
            if (i > 0) begin
               check("prbs", fb, PRBS_BIT);
            end
            fb   = k ? ^{lfsr[13:11], lfsr[1:0]} : lfsr[8] ^ lfsr[4];
            lfsr = k ? {lfsr[13:0], fb} : {6'h00, lfsr[7:0], fb};
         end
         PRBS_ADVANCE <= 1'b0;
      end
      // Timer targets: coarse at count 0x120, fine at count 0x121
      wr(link_regs_pkg::ADDR_COARSE_TIMER_TARGET, 32'h0000_0012);
      wr(link_regs_pkg::ADDR_FINE_TIMER_TARGET, 32'h0000_0121);
      BASE_TIME_COUNT <= 27'h000_0121;
      repeat (3) @(posedge REF_CLK);
      wr(link_regs_pkg::ADDR_EVENT_CLEAR, 32'h0000_0007);
      rd_chk("no_retrig", link_regs_pkg::ADDR_EVENT_STATUS, 32'h0000_0000);
      BASE_TIME_COUNT <= 27'h000_0120;
      repeat (3) @(posedge REF_CLK);
      rd_chk("coarse", link_regs_pkg::ADDR_EVENT_STATUS, 32'h0000_0002);
      BASE_TIME_COUNT <= 27'h000_0121;
      repeat (3) @(posedge REF_CLK);
      rd_chk("fine", link_regs_pkg::ADDR_EVENT_STATUS, 32'h0000_0006);
      check("irq_tim", 1'b1, IRQ);
      // Base time capture
      BASE_TIME_COUNT <= 27'h543_2109;
      wr(link_regs_pkg::ADDR_CAPTURE_TRIGGER, 32'h0000_0001);
      rd_chk("sample", link_regs_pkg::ADDR_BASE_TIME_SAMPLE, 32'h0543_2109);
      rd_chk("capture_now_bit", link_regs_pkg::ADDR_CAPTURE_TRIGGER, 32'h0000_0000);
      complete_run();
   end
endmodule // tb_link_core_crypto_test_timer_regs
`default_nettype wire
